// ### rtl/usb_fifo_pkg.sv
// Purpose: Shared constants and types for the endpoint data port
// Assumes: One clock, synchronous active-low reset
// Notes:   Address map is word aligned; window picks the access width
package usb_fifo_pkg;
   localparam int NUM_EP = 8;
   localparam int EP_W   = 3;
   localparam int QDEPTH = 8;
   localparam int QPTR_W = 3;
   localparam int QCNT_W = 4;
   localparam int ADDR_W = 8;

   // Address fields: addr[7:5] window, addr[4:2] endpoint
   localparam int EP_LSB  = 2;
   localparam int WIN_LSB = 5;
   localparam logic [2:0] WIN_WORD   = 3'h0;
   localparam logic [2:0] WIN_HALF   = 3'h1;
   localparam logic [2:0] WIN_BYTE   = 3'h2;
   localparam logic [2:0] WIN_STATUS = 3'h3;
   localparam logic [7:0] STATUS_OFFSET = 8'h60;

   // Status word fields
   localparam int STAT_TX_EMPTY_LSB = 0;
   localparam int STAT_RX_AVAIL_LSB = 8;

   localparam logic [31:0] DATA_RESET = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   localparam logic [2:0] N_BYTE = 3'h1;
   localparam logic [2:0] N_HALF = 3'h2;
   localparam logic [2:0] N_WORD = 3'h4;

   typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
   typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_RESP = 1'b1} rd_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } link_byte_t;

   function automatic logic [3:0] lane_mask(input logic [2:0] nbytes);
      case (nbytes)
         N_BYTE:  lane_mask = 4'h1;
         N_HALF:  lane_mask = 4'h3;
         default: lane_mask = 4'hf;
      endcase
   endfunction : lane_mask

   function automatic logic [31:0] lane_bits(input logic [3:0] m);
      lane_bits = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
   endfunction : lane_bits
endpackage : usb_fifo_pkg

// ### rtl/access_decode.sv
// Purpose: Split a port address into endpoint, width and target
// Assumes: Word-aligned addresses only
// Notes:   Misaligned or unknown addresses decode to nothing
`timescale 1ns/10ps
module access_decode (
   // Address in
   input  wire logic [usb_fifo_pkg::ADDR_W-1:0] addr,
   // Decoded fields
   output logic [usb_fifo_pkg::EP_W-1:0]   ep,
   output logic [2:0]                      nbytes,
   output logic                            is_data,
   output logic                            is_status
);
   always_comb begin
      ep        = addr[usb_fifo_pkg::EP_LSB +: usb_fifo_pkg::EP_W];
      nbytes    = usb_fifo_pkg::N_WORD;
      is_data   = 1'b0;
      is_status = 1'b0;
      if (addr[1:0] == 2'b00) begin
         case (addr[usb_fifo_pkg::WIN_LSB +: 3])
            usb_fifo_pkg::WIN_WORD: begin
               is_data = 1'b1;
            end
            usb_fifo_pkg::WIN_HALF: begin
               is_data = 1'b1;
               nbytes  = usb_fifo_pkg::N_HALF;
            end
            usb_fifo_pkg::WIN_BYTE: begin
               is_data = 1'b1;
               nbytes  = usb_fifo_pkg::N_BYTE;
            end
            usb_fifo_pkg::WIN_STATUS: begin
               is_status = (addr == usb_fifo_pkg::STATUS_OFFSET);
            end
            default: begin
               is_data = 1'b0;
            end
         endcase
      end
   end
endmodule : access_decode

// ### rtl/byte_queue.sv
// Purpose: Byte queue with up to four bytes in and out per cycle
// Assumes: Caller never pushes past full nor pops past empty
// Notes:   Head bytes beyond the fill level read as zero
`timescale 1ns/10ps
module byte_queue (
   // Clock and reset
   input  wire logic                            aclk,
   input  wire logic                            aresetn,
   // Push side, byte 0 in lane 0
   input  wire logic                            push_en,
   input  wire logic [2:0]                      push_n,
   input  wire logic [31:0]                     push_data,
   // Pop side
   input  wire logic                            pop_en,
   input  wire logic [2:0]                      pop_n,
   output logic [31:0]                          head_data,
   output logic [usb_fifo_pkg::QCNT_W-1:0]      count
);
   localparam int PW = usb_fifo_pkg::QPTR_W;
   localparam int CW = usb_fifo_pkg::QCNT_W;

   logic [7:0]    mem_r [usb_fifo_pkg::QDEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [CW-1:0] cnt_r;
   logic [2:0]    add_n;
   logic [2:0]    sub_n;

   assign add_n = push_en ? push_n : 3'h0;
   assign sub_n = pop_en ? pop_n : 3'h0;
   assign count = cnt_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r    <= '0;
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         cnt_r    <= cnt_r + CW'(add_n) - CW'(sub_n);
         wr_ptr_r <= wr_ptr_r + PW'(add_n);
         rd_ptr_r <= rd_ptr_r + PW'(sub_n);
      end
   end

   // Storage needs no reset: the level gates what is seen
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 4; i++) begin
         if (3'(i) < add_n) begin
            mem_r[wr_ptr_r + PW'(i)] <= push_data[8*i +: 8];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         head_data[8*i +: 8] = (CW'(i) < cnt_r) ? mem_r[rd_ptr_r + PW'(i)] : 8'h00;
      end
   end
endmodule : byte_queue

// ### rtl/usb_endpoint_fifo_port.sv
// Purpose: AXI4-Lite data port onto eight endpoint byte queue pairs
// Assumes: Link side is logic on the same clock
// Notes:   Address window picks 32, 16 or 8 bit access width
`timescale 1ns/10ps
module usb_endpoint_fifo_port (
   // Clock and reset
   input  wire logic                                   aclk,
   input  wire logic                                   aresetn,
   // Write address
   input  wire logic                                   awvalid,
   output logic                                        awready,
   input  wire logic [usb_fifo_pkg::ADDR_W-1:0]        awaddr,
   // Write data
   input  wire logic                                   wvalid,
   output logic                                        wready,
   input  wire logic [31:0]                            wdata,
   input  wire logic [3:0]                             wstrb,
   // Write response
   output logic                                        bvalid,
   input  wire logic                                   bready,
   output logic [1:0]                                  bresp,
   // Read address
   input  wire logic                                   arvalid,
   output logic                                        arready,
   input  wire logic [usb_fifo_pkg::ADDR_W-1:0]        araddr,
   // Read data
   output logic                                        rvalid,
   input  wire logic                                   rready,
   output logic [31:0]                                 rdata,
   output logic [1:0]                                  rresp,
   // Link side, transmit bytes out
   output usb_fifo_pkg::link_byte_t [usb_fifo_pkg::NUM_EP-1:0] tx_out,
   input  wire logic [usb_fifo_pkg::NUM_EP-1:0]        tx_ready,
   // Link side, receive bytes in
   input  usb_fifo_pkg::link_byte_t [usb_fifo_pkg::NUM_EP-1:0] rx_in,
   output logic [usb_fifo_pkg::NUM_EP-1:0]             rx_ready
);
   localparam int NE = usb_fifo_pkg::NUM_EP;
   localparam int CW = usb_fifo_pkg::QCNT_W;

   usb_fifo_pkg::wr_state_t   wr_state_r;
   usb_fifo_pkg::wr_state_t   wr_state_nxt;
   usb_fifo_pkg::rd_state_t   rd_state_r;
   usb_fifo_pkg::rd_state_t   rd_state_nxt;

   logic                             aw_got_r;
   logic                             aw_got_nxt;
   logic                             w_got_r;
   logic                             w_got_nxt;
   logic [usb_fifo_pkg::ADDR_W-1:0]  aw_addr_r;
   logic [31:0]                      w_data_r;
   logic [3:0]                       w_strb_r;
   logic                             awready_r;
   logic                             wready_r;
   logic                             bvalid_r;
   logic [1:0]                       bresp_r;
   logic                             arready_r;
   logic                             rvalid_r;
   logic [31:0]                      rdata_r;
   logic [1:0]                       rresp_r;
   logic [2:0]                       rd_n_r;

   logic [usb_fifo_pkg::EP_W-1:0]    wr_ep;
   logic [2:0]                       wr_n;
   logic                             wr_is_data;
   logic                             wr_is_status;
   logic [usb_fifo_pkg::EP_W-1:0]    rd_ep;
   logic [2:0]                       rd_n;
   logic                             rd_is_data;
   logic                             rd_is_status;

   logic                             wr_commit;
   logic                             wr_fits;
   logic                             wr_strb_ok;
   logic                             wr_ok;
   logic [1:0]                       wr_resp;
   logic                             ar_hs;
   logic [CW-1:0]                    rd_avail;
   logic [2:0]                       rd_take;
   logic [31:0]                      rd_word;
   logic [1:0]                       rd_resp;
   logic [31:0]                      status_word;

   logic [CW-1:0]                    tx_cnt [NE];
   logic [31:0]                      tx_head [NE];
   logic [CW-1:0]                    rx_cnt [NE];
   logic [31:0]                      rx_head [NE];
   logic [NE-1:0]                    tx_push;
   logic [NE-1:0]                    tx_load;
   logic [NE-1:0]                    rx_push;
   logic [NE-1:0]                    rx_pop;
   usb_fifo_pkg::link_byte_t [NE-1:0] tx_out_r;
   logic [NE-1:0]                    rx_ready_r;

   access_decode u_wr_dec (.addr(aw_addr_r), .ep(wr_ep), .nbytes(wr_n),
      .is_data(wr_is_data), .is_status(wr_is_status));
   access_decode u_rd_dec (.addr(araddr), .ep(rd_ep), .nbytes(rd_n),
      .is_data(rd_is_data), .is_status(rd_is_status));

   // Write side: address and data may arrive in either order
   assign wr_commit  = (wr_state_r == usb_fifo_pkg::WR_IDLE) && aw_got_r && w_got_r;
   assign wr_fits    = ({1'b0, tx_cnt[wr_ep]} + {2'b00, wr_n}) <= 5'(usb_fifo_pkg::QDEPTH);
   // Strobes must cover every lane the width moves
   assign wr_strb_ok = (w_strb_r & usb_fifo_pkg::lane_mask(wr_n))
                       == usb_fifo_pkg::lane_mask(wr_n);
   assign wr_ok      = wr_is_data && wr_fits && wr_strb_ok;

   assign wr_resp = wr_ok        ? usb_fifo_pkg::RESP_OKAY
                  : wr_is_data   ? usb_fifo_pkg::RESP_SLVERR
                  : wr_is_status ? usb_fifo_pkg::RESP_OKAY : usb_fifo_pkg::RESP_DECERR;

   always_comb begin
      wr_state_nxt = wr_state_r;
      aw_got_nxt   = aw_got_r | (awvalid & awready_r);
      w_got_nxt    = w_got_r | (wvalid & wready_r);
      case (wr_state_r)
         usb_fifo_pkg::WR_IDLE: begin
            if (wr_commit) begin
               wr_state_nxt = usb_fifo_pkg::WR_RESP;
               aw_got_nxt   = 1'b0;
               w_got_nxt    = 1'b0;
            end
         end
         usb_fifo_pkg::WR_RESP: begin
            if (bready) begin
               wr_state_nxt = usb_fifo_pkg::WR_IDLE;
            end
         end
         default: begin
            wr_state_nxt = usb_fifo_pkg::WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_r <= usb_fifo_pkg::WR_IDLE;
         aw_got_r   <= 1'b0;
         w_got_r    <= 1'b0;
         awready_r  <= 1'b0;
         wready_r   <= 1'b0;
         bvalid_r   <= 1'b0;
         bresp_r    <= usb_fifo_pkg::RESP_OKAY;
      end else begin
         wr_state_r <= wr_state_nxt;
         aw_got_r   <= aw_got_nxt;
         w_got_r    <= w_got_nxt;
         awready_r  <= !aw_got_nxt && (wr_state_nxt == usb_fifo_pkg::WR_IDLE);
         wready_r   <= !w_got_nxt && (wr_state_nxt == usb_fifo_pkg::WR_IDLE);
         bvalid_r   <= (wr_state_nxt == usb_fifo_pkg::WR_RESP);
         if (wr_commit) begin
            bresp_r <= wr_resp;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_r <= '0;
         w_data_r  <= usb_fifo_pkg::DATA_RESET;
         w_strb_r  <= 4'h0;
      end else begin
         if (awvalid && awready_r) begin
            aw_addr_r <= awaddr;
         end
         if (wvalid && wready_r) begin
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
      end
   end

   // Read side: short reads drain what is left
   assign ar_hs    = arvalid && arready_r;
   assign rd_avail = rx_cnt[rd_ep];
   assign rd_take  = ({1'b0, rd_n} <= rd_avail) ? rd_n : rd_avail[2:0];
   assign rd_word  = rx_head[rd_ep]
                     & usb_fifo_pkg::lane_bits(usb_fifo_pkg::lane_mask(rd_n));

   always_comb begin
      status_word = '0;
      for (int e = 0; e < NE; e++) begin
         status_word[usb_fifo_pkg::STAT_TX_EMPTY_LSB + e] = (tx_cnt[e] == '0);
         status_word[usb_fifo_pkg::STAT_RX_AVAIL_LSB + e] = (rx_cnt[e] != '0);
      end
   end

   assign rd_resp = rd_is_data   ? ((rd_avail == '0) ? usb_fifo_pkg::RESP_SLVERR
                                                     : usb_fifo_pkg::RESP_OKAY)
                  : rd_is_status ? usb_fifo_pkg::RESP_OKAY : usb_fifo_pkg::RESP_DECERR;

   always_comb begin
      rd_state_nxt = rd_state_r;
      case (rd_state_r)
         usb_fifo_pkg::RD_IDLE: begin
            if (ar_hs) begin
               rd_state_nxt = usb_fifo_pkg::RD_RESP;
            end
         end
         usb_fifo_pkg::RD_RESP: begin
            if (rready) begin
               rd_state_nxt = usb_fifo_pkg::RD_IDLE;
            end
         end
         default: begin
            rd_state_nxt = usb_fifo_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r <= usb_fifo_pkg::RD_IDLE;
         arready_r  <= 1'b0;
         rvalid_r   <= 1'b0;
         rdata_r    <= usb_fifo_pkg::DATA_RESET;
         rresp_r    <= usb_fifo_pkg::RESP_OKAY;
         rd_n_r     <= usb_fifo_pkg::N_WORD;
      end else begin
         rd_state_r <= rd_state_nxt;
         arready_r  <= (rd_state_nxt == usb_fifo_pkg::RD_IDLE);
         rvalid_r   <= (rd_state_nxt == usb_fifo_pkg::RD_RESP);
         if (ar_hs) begin
            rresp_r <= rd_resp;
            rd_n_r  <= rd_n;
            if (rd_is_data) begin
               rdata_r <= rd_word;
            end else if (rd_is_status) begin
               rdata_r <= status_word;
            end else begin
               rdata_r <= usb_fifo_pkg::DATA_RESET;
            end
         end
      end
   end

   // One queue pair per endpoint
   for (genvar e = 0; e < NE; e++) begin : g_ep
      assign tx_push[e] = wr_commit && wr_ok && (wr_ep == e);
      assign rx_pop[e]  = ar_hs && rd_is_data && (rd_ep == e) && (rd_take != 3'h0);
      assign tx_load[e] = (tx_cnt[e] != '0) && (!tx_out_r[e].valid || tx_ready[e]);
      assign rx_push[e] = rx_in[e].valid && rx_ready_r[e];

      byte_queue u_tx (.aclk(aclk), .aresetn(aresetn), .push_en(tx_push[e]), .push_n(wr_n),
         .push_data(w_data_r), .pop_en(tx_load[e]), .pop_n(usb_fifo_pkg::N_BYTE),
         .head_data(tx_head[e]), .count(tx_cnt[e]));
      byte_queue u_rx (.aclk(aclk), .aresetn(aresetn), .push_en(rx_push[e]),
         .push_n(usb_fifo_pkg::N_BYTE), .push_data({24'h00_0000, rx_in[e].data}),
         .pop_en(rx_pop[e]), .pop_n(rd_take), .head_data(rx_head[e]), .count(rx_cnt[e]));
   end

   // Registered link stage keeps outputs off the queue read mux
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_out_r   <= '0;
         rx_ready_r <= '0;
      end else begin
         for (int e = 0; e < NE; e++) begin
            if (tx_load[e]) begin
               tx_out_r[e].valid <= 1'b1;
               tx_out_r[e].data  <= tx_head[e][7:0];
            end else if (tx_ready[e]) begin
               tx_out_r[e].valid <= 1'b0;
            end
            // Two free slots: one push may land before this is seen
            rx_ready_r[e] <= rx_cnt[e] < CW'(usb_fifo_pkg::QDEPTH - 1);
         end
      end
   end

   assign awready  = awready_r;
   assign wready   = wready_r;
   assign bvalid   = bvalid_r;
   assign bresp    = bresp_r;
   assign arready  = arready_r;
   assign rvalid   = rvalid_r;
   assign rdata    = rdata_r;
   assign rresp    = rresp_r;
   assign tx_out   = tx_out_r;
   assign rx_ready = rx_ready_r;

   chk_one_endpoint: assert property (@(posedge aclk) disable iff (!aresetn)
      $onehot0(tx_push) && $onehot0(rx_pop)) else $error("more than one endpoint touched");
   chk_tx_push_level: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_commit && wr_ok && !tx_load[wr_ep]
      |=> tx_cnt[$past(wr_ep)] == $past(tx_cnt[wr_ep]) + CW'($past(wr_n)))
      else $error("transmit level did not grow by width");
   chk_full_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_commit && wr_is_data && !wr_fits |=> bvalid_r && bresp_r == 2'h2)
      else $error("write past full not refused");
   chk_rx_pop_level: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && rd_is_data && !rx_push[rd_ep]
      |=> rx_cnt[$past(rd_ep)] == $past(rx_cnt[rd_ep]) - CW'($past(rd_take)))
      else $error("receive level did not drop by bytes read");
   chk_short_read: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && rd_is_data && rd_avail != '0 && {1'b0, rd_n} > rd_avail
      |=> rvalid_r && rresp_r == 2'h0) else $error("short last read refused");
   chk_empty_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && rd_is_data && rd_avail == '0
      |=> rvalid_r && rdata_r == 32'h0000_0000 && rresp_r == 2'h2)
      else $error("empty read not zero with error");
   chk_low_lanes: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_r && rd_n_r == 3'h1 |-> rdata_r[31:8] == 24'h00_0000)
      else $error("byte read uses upper lanes");
   chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_r && !rready |=> rvalid_r && $stable(rdata_r) && $stable(rresp_r))
      else $error("read answer dropped before taken");
   chk_tx_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      tx_out_r[0].valid && !tx_ready[0] |=> tx_out_r[0].valid && $stable(tx_out_r[0].data))
      else $error("link byte changed while stalled");
endmodule : usb_endpoint_fifo_port

// ### tb/link_model.sv
// Purpose: Link-side partner, sinks transmit bytes and sources receive bytes
// Assumes: Same clock as the port
// Notes:   Idle receive data inverts its previous value every cycle, never a held value
`timescale 1ns/10ps
module link_model (
   // Clock and stall pattern
   input  wire logic                                           aclk,
   input  wire logic [7:0]                                     stall,
   // Transmit side
   input  usb_fifo_pkg::link_byte_t [usb_fifo_pkg::NUM_EP-1:0] tx_out,
   output logic [usb_fifo_pkg::NUM_EP-1:0]                     tx_ready,
   // Receive side
   output usb_fifo_pkg::link_byte_t [usb_fifo_pkg::NUM_EP-1:0] rx_in,
   input  wire logic [usb_fifo_pkg::NUM_EP-1:0]                rx_ready
);
   logic [7:0] txq [8][$];
   logic [7:0] rxq [8][$];

   initial begin
      tx_ready = '0;
      rx_in    = '0;
   end

   always @(posedge aclk) begin
      for (int e = 0; e < 8; e++) begin
         if (tx_out[e].valid && tx_ready[e])
            txq[e].push_back(tx_out[e].data);
         if (rx_in[e].valid && rx_ready[e])
            void'(rxq[e].pop_front());
         tx_ready[e]    <= ~stall[e];
         rx_in[e].valid <= rxq[e].size() > 0;
         rx_in[e].data  <= (rxq[e].size() > 0) ? rxq[e][0] : ~rx_in[e].data;
      end
   end
endmodule : link_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the endpoint data port
// Assumes: Link model drains and feeds the queues on the same clock
// Notes:   Widths and data random from a fixed seed; one width per packet, tail bytes through the byte window
`timescale 1ns/10ps
module tb_top;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr, tx_ready, rx_ready, stall;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   usb_fifo_pkg::link_byte_t [7:0] tx_out, rx_in;
   logic [7:0]  exp_tx [8][$];
   logic [7:0]  exp_rx [8][$];
   int          seed = 86209;
   int          n_mismatch = 0;
   int          checks = 0;

   usb_endpoint_fifo_port DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .tx_out(tx_out),
      .tx_ready(tx_ready), .rx_in(rx_in), .rx_ready(rx_ready));
   link_model link (.aclk(aclk), .stall(stall), .tx_out(tx_out), .tx_ready(tx_ready),
      .rx_in(rx_in), .rx_ready(rx_ready));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   always @(posedge aclk) stall <= 8'($random(seed));

   function automatic logic [7:0] adr(input int w, input int e);
      adr = 8'(w * 32 + e * 4);
   endfunction : adr

   task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %0t data %h expected %h", $time, g, e);
      end
   endtask : cmp_data

   task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %0t response %h expected %h", $time, g, e);
      end
   endtask : cmp_resp

   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                            output logic [1:0] rs);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= v;
      wstrb   <= s;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr  <= a;
      // Late rready now and then, so a held answer is exercised
      rready  <= 1'($random(seed));
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      v  = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // Short tail goes through the byte window to close odd packets
   task automatic send_pkt(input int e);
      int w, nb, len, k;
      logic [31:0] v;
      logic [1:0]  rs;
      w   = $unsigned($random(seed)) % 3;
      nb  = 4 >> w;
      len = 1 + $unsigned($random(seed)) % 11;
      for (int i = 0; i < len; i += k) begin
         k = (len - i >= nb) ? nb : 1;
         v = $random(seed);
         do axi_write(adr(k == nb ? w : 2, e), v, 4'hf, rs);
         while (rs === usb_fifo_pkg::RESP_SLVERR);
         cmp_resp(rs, usb_fifo_pkg::RESP_OKAY);
         for (int j = 0; j < k; j++) exp_tx[e].push_back(v[8*j +: 8]);
      end
   endtask : send_pkt

   task automatic recv_pkt(input int e);
      int w, nb;
      logic [31:0] x, v;
      logic [1:0]  rs;
      w  = $unsigned($random(seed)) % 3;
      nb = 4 >> w;
      while (exp_rx[e].size() > 0) begin
         x = '0;
         for (int j = 0; j < nb && exp_rx[e].size() > 0; j++) x[8*j +: 8] = exp_rx[e].pop_front();
         axi_read(adr(w, e), v, rs);
         cmp_resp(rs, usb_fifo_pkg::RESP_OKAY);
         cmp_data(v, x);
      end
      axi_read(adr(w, e), v, rs);
      cmp_resp(rs, usb_fifo_pkg::RESP_SLVERR);
      cmp_data(v, 32'h0000_0000);
   endtask : recv_pkt

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   // Whole run is at most about a thousand cycles; the limit lies at 20000
   initial begin
      #1_000_000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
      {awaddr, araddr, wdata, wstrb, stall} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(8'h60, d, r);
      cmp_data(d, 32'h0000_00ff);
      axi_read(8'h00, d, r);
      cmp_data(d, 32'h0000_0000);
      axi_write(8'h00, 32'h1234_5678, 4'h1, r);
      cmp_resp(r, usb_fifo_pkg::RESP_SLVERR);
      axi_write(8'h41, 32'h1234_5678, 4'hf, r);
      cmp_resp(r, usb_fifo_pkg::RESP_DECERR);
      axi_write(8'h60, 32'h1234_5678, 4'hf, r);
      cmp_resp(r, usb_fifo_pkg::RESP_OKAY);
      axi_read(8'h80, d, r);
      cmp_resp(r, usb_fifo_pkg::RESP_DECERR);
      for (int e = 0; e < 8; e++) send_pkt(e);
      repeat (200) @(posedge aclk);
      for (int e = 0; e < 8; e++) begin
         cmp_data(32'(link.txq[e].size()), 32'(exp_tx[e].size()));
         for (int i = 0; i < exp_tx[e].size(); i++)
            cmp_data({24'h0, link.txq[e][i]}, {24'h0, exp_tx[e][i]});
      end
      @(negedge aclk);
      for (int e = 0; e < 8; e++)
         repeat (1 + $unsigned($random(seed)) % 7) begin
            d[7:0] = 8'($random(seed));
            link.rxq[e].push_back(d[7:0]);
            exp_rx[e].push_back(d[7:0]);
         end
      repeat (40) @(posedge aclk);
      axi_read(8'h60, d, r);
      cmp_data(d, 32'h0000_ffff);
      for (int e = 0; e < 8; e++) recv_pkt(e);
      give_verdict();
   end
endmodule : tb_top
